// file: rtl/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
module byte_fifo
  import midi_router_pkg::*;
#(
  parameter int unsigned WIDTH = BYTE_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Full and empty come straight from the fill count.
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];

  // Storage writes only; no reset needed on the data array.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which keeps non-power-of-two depths legal.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (reset)
    cnt_r <= (AW+1)'(DEPTH)) else $error("FIFO count exceeds depth.");

endmodule : byte_fifo

// file: rtl/midi_port_router.sv
// Message router between internal source and sink and the serial ports.
module midi_port_router
  import midi_router_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           reset,
  input  wire logic           port_set_select,
  input  wire logic           output_function_select,
  input  wire host_speed_type host_speed,
  input  wire logic           midi_in,
  output logic                midi_output_function_select,
  output logic                timecode_output_port,
  input  wire logic           host_rx,
  output logic                host_tx,
  input  wire logic [7:0]     int_tx_data,
  input  wire logic           int_tx_valid,
  output logic                int_tx_ready,
  input  wire logic [7:0]     tc_data,
  input  wire logic           tc_valid,
  output logic                tc_ready,
  output byte_beat_type       rx_msg,
  output logic                ports_host
);

  logic [15:0]   host_cyc;
  logic          sel_r;
  logic          func_r;
  logic          pend_sel_r;
  logic          pend_func_r;
  logic          midi_rx_busy;
  logic          host_rx_busy;
  logic          out_busy;
  logic          hst_busy;
  byte_beat_type midi_rx_beat;
  byte_beat_type host_rx_beat;
  logic          thru_mode;
  logic [7:0]    q_data;
  logic          q_valid;
  logic          q_ready;
  logic          q_in_ready;
  logic          q_in_valid;
  logic [7:0]    q_in_data;
  logic          out_load;
  logic          hst_load;
  logic          quiet;

  // Host bit period from the chosen speed.
  always_comb begin
    case (host_speed)
      host_speed_low:           host_cyc = LOW_BIT_CYC;
      host_speed_high:          host_cyc = HIGH_BIT_CYC;
      host_speed_alt_interface: host_cyc = ALT_BIT_CYC;
      default:                  host_cyc = LOW_BIT_CYC;
    endcase
  end

  // Settings also wait for an empty queue, no byte entering it and an idle live input line.
  // A byte queued under one mode must never leave under the other. A receiver must not start
  // in the very cycle its port set is switched off. A source that never drops valid, or a
  // live line held low, therefore holds off a change.
  assign quiet = !midi_rx_busy && !host_rx_busy && !out_busy && !hst_busy && !q_valid &&
                 !(q_in_valid && q_in_ready) &&
                 ((sel_r == PORTS_MIDI) ? midi_in : host_rx);

  // Settings change only while both port sets are quiet, so a frame is never cut in half.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_r       <= PORTS_MIDI;
      func_r      <= FUNC_OUT;
      pend_sel_r  <= PORTS_MIDI;
      pend_func_r <= FUNC_OUT;
    end else begin
      pend_sel_r  <= port_set_select;
      pend_func_r <= output_function_select;
      if (quiet) begin
        sel_r  <= pend_sel_r;
        func_r <= pend_func_r;
      end
    end
  end

  assign ports_host = sel_r;
  assign thru_mode  = (sel_r == PORTS_MIDI) && (func_r == FUNC_THRU);

  // Receivers: the idle port's receiver is held off so only one set is live.
  serial_rx u_midi_rx (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (sel_r == PORTS_MIDI),
    .bit_cyc (MIDI_BIT_CYC),
    .line_in (midi_in),
    .busy    (midi_rx_busy),
    .beat    (midi_rx_beat)
  );

  serial_rx u_host_rx (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (sel_r == PORTS_HOST),
    .bit_cyc (host_cyc),
    .line_in (host_rx),
    .busy    (host_rx_busy),
    .beat    (host_rx_beat)
  );

  // Received bytes go to the internal sink from whichever set is live.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_msg <= '0;
    end else if (sel_r == PORTS_MIDI) begin
      rx_msg <= midi_rx_beat;
    end else begin
      rx_msg <= host_rx_beat;
    end
  end

  // Queue feed: relayed input in pass-through, internal messages otherwise.
  // A relayed byte arriving while the queue is full is dropped; the input has no flow control.
  always_comb begin
    if (thru_mode) begin
      q_in_valid = midi_rx_beat.valid;
      q_in_data  = midi_rx_beat.data;
    end else begin
      q_in_valid = int_tx_valid;
      q_in_data  = int_tx_data;
    end
  end
  assign int_tx_ready = q_in_ready && !thru_mode;

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (q_in_data),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  // Queue drains to the live port set's transmitter only.
  assign out_load = q_valid && !out_busy && (sel_r == PORTS_MIDI);
  assign hst_load = q_valid && !hst_busy && (sel_r == PORTS_HOST);
  assign q_ready  = out_load || hst_load;

  serial_tx u_out_tx (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .bit_cyc  (MIDI_BIT_CYC),
    .load     (out_load),
    .data     (q_data),
    .busy     (out_busy),
    .line_out (midi_output_function_select)
  );

  serial_tx u_host_tx (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .bit_cyc  (host_cyc),
    .load     (hst_load),
    .data     (q_data),
    .busy     (hst_busy),
    .line_out (host_tx)
  );

  // Time-code port ignores both settings entirely.
  logic tc_busy;
  assign tc_ready = !tc_busy;

  serial_tx u_tc_tx (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .bit_cyc  (MIDI_BIT_CYC),
    .load     (tc_valid && !tc_busy),
    .data     (tc_data),
    .busy     (tc_busy),
    .line_out (timecode_output_port)
  );

  reset_sel_a: assert property (@(posedge ref_clk)
    $fell(reset) |-> (sel_r == PORTS_MIDI) && (func_r == FUNC_OUT))
    else $error("Settings not at defaults after reset.");

  thru_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    thru_mode |-> q_in_valid == midi_rx_beat.valid)
    else $error("Internal byte offered to the queue in pass-through.");

  one_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(out_load && hst_load))
    else $error("Both port sets loaded together.");

  host_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel_r == PORTS_MIDI) && !hst_busy |=> host_tx)
    else $error("Host line driven while connectors selected.");

  relay_path_a: assert property (@(posedge ref_clk) disable iff (reset)
    thru_mode && midi_rx_beat.valid && q_in_ready |-> q_in_data == midi_rx_beat.data)
    else $error("Relayed byte altered.");

  tc_free_a: assert property (@(posedge ref_clk) disable iff (reset)
    tc_valid && !tc_busy |=> tc_busy)
    else $error("Time code not started.");

  out_mode_a: assert property (@(posedge ref_clk) disable iff (reset)
    !thru_mode && int_tx_valid && q_in_ready |-> int_tx_ready)
    else $error("Internal byte refused in output mode.");

  host_rate_a: assert property (@(posedge ref_clk) disable iff (reset)
    host_speed == host_speed_high |-> host_cyc == HIGH_BIT_CYC)
    else $error("Host rate wrong.");

  settle_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    q_valid |=> $stable(sel_r) && $stable(func_r))
    else $error("Setting changed with bytes still queued.");

  rx_one_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel_r == PORTS_HOST) |-> !midi_rx_busy)
    else $error("Connector receiver busy while host port selected.");

endmodule : midi_port_router

// Asynchronous frame receiver sampling mid-bit.
module serial_rx
  import midi_router_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        line_in,
  output logic             busy,
  output byte_beat_type    beat
);
  ser_state_type state_r;
  logic [15:0]   cnt_r;
  logic [3:0]    idx_r;
  logic [7:0]    sh_r;

  assign busy = (state_r != SER_IDLE);

  // Start detected on a low line; the first wait is half a bit to land mid-cell.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= SER_IDLE;
      cnt_r   <= '0;
      idx_r   <= '0;
      sh_r    <= '0;
      beat    <= '0;
    end else begin
      beat.valid <= 1'b0;
      if (cnt_r != '0) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        case (state_r)
          SER_IDLE: begin
            if (enable && !line_in) begin
              state_r <= SER_START;
              cnt_r   <= {1'b0, bit_cyc[15:1]};
            end
          end
          SER_START: begin
            state_r <= line_in ? SER_IDLE : SER_DATA;
            cnt_r   <= bit_cyc - 16'h0001;  // One count less, since the sampling edge is a cycle too.
            idx_r   <= '0;
          end
          SER_DATA: begin
            sh_r  <= {line_in, sh_r[7:1]};
            idx_r <= idx_r + 4'h1;
            cnt_r <= bit_cyc - 16'h0001;
            if (idx_r == DATA_BITS - 4'h1) begin
              state_r <= SER_STOP;
            end
          end
          SER_STOP: begin
            state_r <= SER_IDLE;
            if (line_in) begin
              beat.valid <= 1'b1;  // A bad stop bit drops the byte.
              beat.data  <= sh_r;
            end
          end
          default: state_r <= SER_IDLE;
        endcase
      end
    end
  end
endmodule : serial_rx

// Frame transmitter: line idles high.
module serial_tx
  import midi_router_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        load,
  input  wire logic [7:0]  data,
  output logic             busy,
  output logic             line_out
);
  logic [9:0]  sh_r;
  logic [3:0]  idx_r;
  logic [15:0] cnt_r;

  // Shift out start, data LSB first, then stop.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sh_r     <= '1;
      idx_r    <= '0;
      cnt_r    <= '0;
      busy     <= 1'b0;
      line_out <= 1'b1;
    end else if (!busy) begin
      if (load) begin
        sh_r     <= {1'b1, data, 1'b0};
        busy     <= 1'b1;
        idx_r    <= '0;
        cnt_r    <= '0;
      end
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 16'h0001;
    end else if (idx_r == FRAME_BITS) begin
      busy <= 1'b0;
    end else begin
      line_out <= sh_r[0];
      sh_r     <= {1'b1, sh_r[9:1]};
      idx_r    <= idx_r + 4'h1;
      cnt_r    <= bit_cyc - 16'h0001;
    end
  end
endmodule : serial_tx

// file: rtl/midi_router_pkg.sv
// Package with constants and carrier types for the serial message port router.
package midi_router_pkg;

  // Clock rate and serial bit rates.
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned MIDI_BPS      = 31250;
  localparam int unsigned HOST_LOW_BPS  = 31250;
  localparam int unsigned HOST_HIGH_BPS = 38400;
  localparam int unsigned HOST_ALT_BPS  = 31250;

  // Cycles per bit, rounded down so a bit never stretches past its slot.
  localparam logic [15:0] MIDI_BIT_CYC  = 16'(CLK_HZ / MIDI_BPS);
  localparam logic [15:0] LOW_BIT_CYC   = 16'(CLK_HZ / HOST_LOW_BPS);
  localparam logic [15:0] HIGH_BIT_CYC  = 16'(CLK_HZ / HOST_HIGH_BPS);
  localparam logic [15:0] ALT_BIT_CYC   = 16'(CLK_HZ / HOST_ALT_BPS);

  // Frame layout: start bit, eight data bits, stop bit.
  localparam logic [3:0]  FRAME_BITS    = 4'hA;
  localparam logic [3:0]  DATA_BITS     = 4'h8;
  localparam logic [3:0]  STOP_IDX      = 4'h9;

  // Buffer shape.
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 8;

  // Settings and their reset values.
  localparam logic        PORTS_MIDI    = 1'b0;
  localparam logic        PORTS_HOST    = 1'b1;
  localparam logic        FUNC_OUT      = 1'b0;
  localparam logic        FUNC_THRU     = 1'b1;

  // Host speed choices.
  typedef enum logic [1:0] {
    host_speed_low           = 2'h0,
    host_speed_high          = 2'h1,
    host_speed_alt_interface = 2'h3
  } host_speed_type;

  // Receiver states, Gray-coded along the frame.
  typedef enum logic [1:0] {
    SER_IDLE  = 2'h0,
    SER_START = 2'h1,
    SER_DATA  = 2'h3,
    SER_STOP  = 2'h2
  } ser_state_type;

  // A byte travelling with its valid flag.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_type;

endpackage : midi_router_pkg

// file: testbench/midi_far_end.sv
// Far-end serial device model: sends frames and decodes the block's lines.
module midi_far_end (
  input  wire logic ref_clk,
  input  wire logic midi_output_function_select,
  input  wire logic host_tx,
  input  wire logic timecode_output_port,
  output logic      midi_in,
  output logic      host_rx
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both lines idle high between frames, like a current loop at rest.
  initial begin
    midi_in = 1'b1;
    host_rx = 1'b1;
  end

  function automatic logic line_of(input int sel);
    case (sel)
      0: return midi_output_function_select;
      1: return host_tx;
      default: return timecode_output_port;
    endcase
  endfunction : line_of

  // Start bit, eight data bits LSB first, stop bit; the line is left high.
  task automatic put(input int sel, input int cyc, input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      if (sel == 0) midi_in = fr[i];
      else host_rx = fr[i];
      repeat (cyc - 1) @(negedge ref_clk);
    end
  endtask : put

  // Samples mid-bit; gives up when no start bit shows within the wait.
  task automatic get(input int sel, input int cyc, output logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    d = 8'h00;
    while (line_of(sel) !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n < 5000) begin
      repeat (cyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (cyc) @(posedge ref_clk);
        d[i] = line_of(sel);
      end
      repeat (cyc) @(posedge ref_clk);
      ok = (line_of(sel) === 1'b1);
    end
  endtask : get
endmodule : midi_far_end

// file: testbench/testbench.sv
// Self-checking bench for the serial message port router.
module testbench;
  import midi_router_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic           ref_clk = 1'b0;
  logic           reset = 1'b1;
  logic           port_set_select = 1'b0;
  logic           output_function_select = 1'b0;
  host_speed_type host_speed = host_speed_low;
  wire logic      midi_in;
  wire logic      host_rx;
  logic           midi_output_function_select;
  logic           timecode_output_port;
  logic           host_tx;
  logic [7:0]     int_tx_data = 8'h00;
  logic           int_tx_valid = 1'b0;
  logic           int_tx_ready;
  logic [7:0]     tc_data = 8'h00;
  logic           tc_valid = 1'b0;
  logic           tc_ready;
  byte_beat_type  rx_msg;
  logic           ports_host;
  int             err_total = 0;
  int             checks_done = 0;
  int             mo_lows = 0;
  int             ht_lows = 0;
  logic [7:0]     rx_q[$];

  midi_port_router i_midi_port_router (
    .ref_clk(ref_clk), .reset(reset), .port_set_select(port_set_select),
    .output_function_select(output_function_select), .host_speed(host_speed),
    .midi_in(midi_in), .midi_output_function_select(midi_output_function_select),
    .timecode_output_port(timecode_output_port), .host_rx(host_rx), .host_tx(host_tx),
    .int_tx_data(int_tx_data), .int_tx_valid(int_tx_valid), .int_tx_ready(int_tx_ready),
    .tc_data(tc_data), .tc_valid(tc_valid), .tc_ready(tc_ready),
    .rx_msg(rx_msg), .ports_host(ports_host)
  );

  midi_far_end i_midi_far_end (
    .ref_clk(ref_clk), .midi_output_function_select(midi_output_function_select), .host_tx(host_tx),
    .timecode_output_port(timecode_output_port), .midi_in(midi_in), .host_rx(host_rx)
  );

  // Clock at 10 MHz.
  always #50 ref_clk = ~ref_clk;

  // Collects received bytes and counts low cycles on lines that must stay idle.
  always @(posedge ref_clk) begin
    if (rx_msg.valid === 1'b1) rx_q.push_back(rx_msg.data);
    if (midi_output_function_select === 1'b0) mo_lows++;
    if (host_tx === 1'b0) ht_lows++;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_frame(input string nm, input logic [7:0] exp, input bit ok,
                           input logic [7:0] d);
    chk(nm, {7'h00, 1'b1, exp}, {7'h00, ok, d});
  endtask : chk_frame

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Ready is combinational, so it is read once the falling-edge drive has settled.
  task automatic push(input bit tc, input logic [7:0] d, output bit acc);
    @(negedge ref_clk);
    if (tc) begin
      tc_data = d;
      tc_valid = 1'b1;
    end else begin
      int_tx_data = d;
      int_tx_valid = 1'b1;
    end
    #1 acc = tc ? tc_ready : int_tx_ready;
    @(posedge ref_clk);
  endtask : push

  task automatic drop();
    @(negedge ref_clk);
    int_tx_valid = 1'b0;
    tc_valid = 1'b0;
  endtask : drop

  // Waits long enough for a transmitter to finish a whole frame before giving up.
  task automatic push_wait(input bit tc, input logic [7:0] d);
    bit acc;
    acc = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      push(tc, d, acc);
      if (acc) break;
    end
    drop();
    chk("accepted", 16'h0001, {15'h0000, acc});
  endtask : push_wait

  task automatic expect_rx(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("rx_msg", {8'h00, exp}, rx_q.size() > 0 ? {8'h00, rx_q.pop_front()} : 16'hFFFF);
  endtask : expect_rx

  // Settings are only applied while both port sets are idle, so leave a few cycles.
  task automatic set_mode(input logic p, input logic f, input host_speed_type s);
    @(negedge ref_clk);
    port_set_select = p;
    output_function_select = f;
    host_speed = s;
    repeat (10) @(negedge ref_clk);
    rx_q.delete();
    mo_lows = 0;
    ht_lows = 0;
  endtask : set_mode

  task automatic t_reset();
    chk("ports_host", 16'h0000, {15'h0000, ports_host});
    chk("int_tx_ready", 16'h0001, {15'h0000, int_tx_ready});
    chk("tc_ready", 16'h0001, {15'h0000, tc_ready});
    chk("idle lines", 16'h0007, {13'h0000, midi_output_function_select, host_tx, timecode_output_port});
    $display("test reset done");
  endtask : t_reset

  // Fills the buffer until it refuses while the far end checks every accepted byte in order.
  task automatic t_fill();
    bit acc;
    bit ok;
    bit refused;
    int n_acc;
    logic [7:0] d;
    set_mode(1'b0, 1'b0, host_speed_low);
    n_acc = 0;
    refused = 1'b0;
    fork
      begin
        for (int i = 0; i < 12 && !refused; i++) begin
          push(1'b0, 8'hA0 + 8'(i), acc);
          if (acc) n_acc++;
          else refused = 1'b1;
        end
        drop();
      end
      for (int i = 0; i < 12; i++) begin
        if (i > 0 && i >= n_acc) break;
        i_midi_far_end.get(0, int'(MIDI_BIT_CYC), d, ok);
        chk_frame("out byte", 8'hA0 + 8'(i), ok, d);
      end
    join
    chk("refused", 16'h0001, {15'h0000, refused});
    chk("filled", 16'h0001, {15'h0000, n_acc >= 8});
    chk("host idle", 16'h0000, ht_lows[15:0]);
    $display("test fill done");
  endtask : t_fill

  // The fill test left many low cycles on the output line, so the count starts afresh here.
  task automatic t_midi_rx();
    mo_lows = 0;
    ht_lows = 0;
    i_midi_far_end.put(0, int'(MIDI_BIT_CYC), 8'hB3);
    expect_rx(8'hB3);
    chk("no relay", 16'h0000, mo_lows[15:0]);
    $display("test midi rx done");
  endtask : t_midi_rx

  task automatic t_thru();
    bit ok;
    logic [7:0] d;
    set_mode(1'b0, 1'b1, host_speed_low);
    chk("int_tx_ready", 16'h0000, {15'h0000, int_tx_ready});
    fork
      i_midi_far_end.put(0, int'(MIDI_BIT_CYC), 8'h5A);
      i_midi_far_end.get(0, int'(MIDI_BIT_CYC), d, ok);
    join
    chk_frame("relayed", 8'h5A, ok, d);
    expect_rx(8'h5A);
    $display("test thru done");
  endtask : t_thru

  // Time code must come out with both settings low and with both settings high.
  task automatic t_tc();
    bit ok;
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      set_mode(k[0], k[0], host_speed_low);
      fork
        push_wait(1'b1, 8'hF0 + 8'(k));
        i_midi_far_end.get(2, int'(MIDI_BIT_CYC), d, ok);
      join
      chk_frame("timecode", 8'hF0 + 8'(k), ok, d);
    end
    $display("test timecode done");
  endtask : t_tc

  // Host port at each rate, sending and receiving at once.
  task automatic t_host();
    bit ok;
    logic [7:0] d;
    host_speed_type sp[3];
    int cy[3];
    sp = '{host_speed_low, host_speed_high, host_speed_alt_interface};
    cy = '{int'(LOW_BIT_CYC), int'(HIGH_BIT_CYC), int'(ALT_BIT_CYC)};
    for (int k = 0; k < 3; k++) begin
      set_mode(1'b1, 1'b0, sp[k]);
      chk("ports_host", 16'h0001, {15'h0000, ports_host});
      fork
        push_wait(1'b0, 8'h90 + 8'(k));
        i_midi_far_end.get(1, cy[k], d, ok);
        i_midi_far_end.put(1, cy[k], 8'h30 + 8'(k));
      join
      chk_frame("host byte", 8'h90 + 8'(k), ok, d);
      expect_rx(8'h30 + 8'(k));
      chk("out idle", 16'h0000, mo_lows[15:0]);
    end
    set_mode(1'b1, 1'b1, host_speed_low);
    i_midi_far_end.put(0, int'(MIDI_BIT_CYC), 8'h66);
    repeat (40) @(posedge ref_clk);
    chk("ignored rx", 16'h0000, 16'(rx_q.size()));
    chk("no relay", 16'h0000, mo_lows[15:0]);
    $display("test host done");
  endtask : t_host

  // Main sequence.
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    t_reset();
    t_fill();
    t_midi_rx();
    t_thru();
    t_tc();
    t_host();
    end_sim();
  end

  // Watchdog sized well above the expected run of about 57000 cycles.
  initial begin
    repeat (95000) @(posedge ref_clk);
    err_total++;
    $display("[ERR] watchdog expected finish seen hang");
    end_sim();
  end
endmodule : testbench
